// >>> shared/rwd_pkg.sv
package rwd_pkg;
    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [4:0] IDX_INT_CTRL   = 5'h06;
    localparam logic [4:0] IDX_WD_CTRL    = 5'h07;
    localparam logic [4:0] IDX_EVT_STATUS = 5'h10;
    localparam logic [4:0] IDX_EVT_MASK   = 5'h11;

    // ---------------------------------------------------------------
    // Interrupt control fields
    // ---------------------------------------------------------------
    localparam int BIT_WD_IRQ_EN  = 7;
    localparam int BIT_ALARM_IRQ_EN = 6;
    localparam int BIT_PF_IRQ_EN  = 5;
    localparam int BIT_SQW_EN     = 4;
    localparam int BIT_ACT_HIGH   = 3;
    localparam int BIT_PULSE_MODE = 2;
    localparam int BIT_SQ_HI      = 1;
    localparam int BIT_SQ_LO      = 0;

    // ---------------------------------------------------------------
    // Watchdog fields
    // ---------------------------------------------------------------
    localparam int BIT_WD_STROBE  = 7;
    localparam int BIT_WD_LOCK    = 6;
    localparam int WD_TMO_MSB     = 5;

    // ---------------------------------------------------------------
    // Event status / mask bits
    // ---------------------------------------------------------------
    localparam int EVT_WD    = 0;
    localparam int EVT_ALARM = 1;
    localparam int EVT_PF    = 2;

    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [7:0] WD_CTRL_RST  = 8'h00;
    localparam logic [2:0] EVT_RST      = 3'h0;
    localparam logic [3:0] PULSE_TICKS  = 4'h8;
endpackage

// >>> src/rwd_top.sv
// Contract
// - Strobe write reloads counter with timeout
// - Lock bit blocks timeout writes, not strobe
// - Timeout equals field times 32 Hz period
// - Alarm enable drives pin and alarm flag
// - Powerfail enable drives pin and flag
module rwd_top (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [6:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    input  wire logic        tick_32hz_in,
    input  wire logic        alarm_match_in,
    input  wire logic        powerfail_in,
    input  wire logic [3:0]  square_in,
    output logic             int_pin_out,
    output logic             int_pin_oe_out,
    output logic             irq_out
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [7:0]  int_ctrl_reg,  int_ctrl_next;
    logic [7:0]  wd_ctrl_reg,   wd_ctrl_next;
    logic [5:0]  wd_count_reg,  wd_count_next;
    logic [2:0]  status_reg,    status_next;
    logic [2:0]  mask_reg,      mask_next;
    logic [3:0]  pulse_reg,     pulse_next;
    logic        ack_reg,       ack_next;
    logic [31:0] rdata_reg,     rdata_next;
    logic        pf_meta_reg,   pf_sync_reg,  pf_prev_reg;
    logic        pin_reg,       pin_next;
    logic        oe_reg,        oe_next;

    logic        req;
    logic        hit;
    logic [2:0]  events;
    logic        src_fire;
    logic        src_level;
    logic        active;
    logic        sq;
    logic        wd_expire;

    function automatic logic sel(input logic [6:0] a, input logic [4:0] idx);
        sel = (a[6:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    // ---------------------------------------------------------------
    // Bus handshake and read data
    // ---------------------------------------------------------------
    always_comb begin
        req        = read_in | write_in;
        hit        = req & ack_reg;
        ack_next   = req & ~ack_reg;
        rdata_next = rdata_reg;

        // Read data is latched in the wait cycle so it stands when waitrequest drops
        if (req && !ack_reg && read_in) begin
            rdata_next = 32'h0000_0000;
            if (sel(address_in, rwd_pkg::IDX_INT_CTRL))
                rdata_next[7:0] = int_ctrl_reg;
            else if (sel(address_in, rwd_pkg::IDX_WD_CTRL))
                rdata_next[7:0] = wd_ctrl_reg;
            else if (sel(address_in, rwd_pkg::IDX_EVT_STATUS))
                rdata_next[2:0] = status_reg;
            else if (sel(address_in, rwd_pkg::IDX_EVT_MASK))
                rdata_next[2:0] = mask_reg;
        end

    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Control registers and watchdog counter
    // ---------------------------------------------------------------
    always_comb begin
        int_ctrl_next = int_ctrl_reg;
        wd_ctrl_next  = wd_ctrl_reg;
        wd_count_next = wd_count_reg;
        mask_next     = mask_reg;
        wd_expire     = 1'b0;

        // Watchdog countdown on the 32 Hz tick; expiry reloads and flags
        if (tick_32hz_in && wd_ctrl_reg[rwd_pkg::WD_TMO_MSB:0] != 6'h00) begin
            if (wd_count_reg <= 6'h01) begin
                wd_expire = 1'b1;
                wd_count_next = wd_ctrl_reg[rwd_pkg::WD_TMO_MSB:0];
            end else begin
                wd_count_next = wd_count_reg - 6'h01;
            end
        end

        if (hit && write_in) begin
            if (sel(address_in, rwd_pkg::IDX_INT_CTRL))
                int_ctrl_next = writedata_in[7:0];
            else if (sel(address_in, rwd_pkg::IDX_EVT_MASK))
                mask_next = writedata_in[2:0];
            else if (sel(address_in, rwd_pkg::IDX_WD_CTRL)) begin
                wd_ctrl_next[rwd_pkg::BIT_WD_LOCK] = writedata_in[rwd_pkg::BIT_WD_LOCK];
                if (!writedata_in[rwd_pkg::BIT_WD_LOCK])
                    wd_ctrl_next[rwd_pkg::WD_TMO_MSB:0] = writedata_in[rwd_pkg::WD_TMO_MSB:0];
                if (writedata_in[rwd_pkg::BIT_WD_STROBE])
                    wd_count_next = wd_ctrl_next[rwd_pkg::WD_TMO_MSB:0];
            end
        end
        // Strobe is self-clearing so it always reads back as zero
        wd_ctrl_next[rwd_pkg::BIT_WD_STROBE] = 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_ctrl_reg <= rwd_pkg::INT_CTRL_RST;
            wd_ctrl_reg  <= rwd_pkg::WD_CTRL_RST;
            wd_count_reg <= 6'h00;
            mask_reg     <= rwd_pkg::EVT_RST;
        end else begin
            int_ctrl_reg <= int_ctrl_next;
            wd_ctrl_reg  <= wd_ctrl_next;
            wd_count_reg <= wd_count_next;
            mask_reg     <= mask_next;
        end
    end

    // ---------------------------------------------------------------
    // Event flags and power-fail synchroniser
    // ---------------------------------------------------------------
    always_comb begin
        events                     = 3'b000;
        events[rwd_pkg::EVT_WD]    = wd_expire;
        events[rwd_pkg::EVT_ALARM] = alarm_match_in & int_ctrl_reg[rwd_pkg::BIT_ALARM_IRQ_EN];
        events[rwd_pkg::EVT_PF]    = pf_sync_reg & ~pf_prev_reg
                                     & int_ctrl_reg[rwd_pkg::BIT_PF_IRQ_EN];

        // Set wins over the clear caused by reading the status
        status_next = status_reg;
        if (hit && read_in && sel(address_in, rwd_pkg::IDX_EVT_STATUS))
            status_next = 3'b000;
        status_next = status_next | events;
    end

    // Only the second stage feeds the edge detector, the first may still be metastable
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status_reg  <= rwd_pkg::EVT_RST;
            pf_meta_reg <= 1'b0;
            pf_sync_reg <= 1'b0;
            pf_prev_reg <= 1'b0;
        end else begin
            status_reg  <= status_next;
            pf_meta_reg <= powerfail_in;
            pf_sync_reg <= pf_meta_reg;
            pf_prev_reg <= pf_sync_reg;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt pin
    // ---------------------------------------------------------------
    always_comb begin
        pulse_next = pulse_reg;
        src_fire  = (events[rwd_pkg::EVT_WD] & int_ctrl_reg[rwd_pkg::BIT_WD_IRQ_EN])
                  | events[rwd_pkg::EVT_ALARM] | events[rwd_pkg::EVT_PF];
        src_level = (status_reg[rwd_pkg::EVT_WD]    & int_ctrl_reg[rwd_pkg::BIT_WD_IRQ_EN])
                  | (status_reg[rwd_pkg::EVT_ALARM] & int_ctrl_reg[rwd_pkg::BIT_ALARM_IRQ_EN])
                  | (status_reg[rwd_pkg::EVT_PF]    & int_ctrl_reg[rwd_pkg::BIT_PF_IRQ_EN]);

        // Pulse length is counted in 32 Hz ticks, so it is only tick-accurate
        if (src_fire)
            pulse_next = rwd_pkg::PULSE_TICKS;
        else if (tick_32hz_in && pulse_reg != 4'h0)
            pulse_next = pulse_reg - 4'h1;

        active = int_ctrl_reg[rwd_pkg::BIT_PULSE_MODE] ? (pulse_reg != 4'h0) : src_level;
        sq     = square_in[{int_ctrl_reg[rwd_pkg::BIT_SQ_HI], int_ctrl_reg[rwd_pkg::BIT_SQ_LO]}];

        // Open drain when active-low: only ever pull low, never drive high
        if (int_ctrl_reg[rwd_pkg::BIT_SQW_EN]) begin
            pin_next = sq;
            oe_next  = int_ctrl_reg[rwd_pkg::BIT_ACT_HIGH] | ~sq;
        end else if (int_ctrl_reg[rwd_pkg::BIT_ACT_HIGH]) begin
            pin_next = active;
            oe_next  = 1'b1;
        end else begin
            pin_next = 1'b0;
            oe_next  = active;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pulse_reg <= 4'h0;
            pin_reg   <= 1'b0;
            oe_reg    <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
            pin_reg   <= pin_next;
            oe_reg    <= oe_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    assign waitrequest_out = (read_in | write_in) & ~ack_reg;
    assign readdata_out    = rdata_reg;
    assign irq_out         = |(status_reg & mask_reg);
    assign int_pin_out     = pin_reg;
    assign int_pin_oe_out  = oe_reg;
endmodule // rwd_top

// >>> verification/rwd_assertions.sv
module rwd_assertions (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic [6:0]  address_in,
    input wire logic        read_in,
    input wire logic        write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [31:0] readdata_out,
    input wire logic        waitrequest_out,
    input wire logic        alarm_match_in,
    input wire logic        powerfail_in,
    input wire logic [3:0]  square_in,
    input wire logic        int_pin_out,
    input wire logic        int_pin_oe_out,
    input wire logic        irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shadow copies of control and mask, since only ports are visible
    logic [7:0] ctrl_reg, ctrl_next, mask_reg, mask_next;
    logic [3:0] sq_reg;
    always_comb begin
        ctrl_next = (write_in && !waitrequest_out && address_in == 7'h18) ? writedata_in[7:0] : ctrl_reg;
        mask_next = (write_in && !waitrequest_out && address_in == 7'h44) ? writedata_in[7:0] : mask_reg;
    end
    always_ff @(posedge clk_in) begin
        ctrl_reg <= reset_in ? 8'h00 : ctrl_next;
        mask_reg <= reset_in ? 8'h00 : mask_next;
        sq_reg   <= square_in;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_rd_done;
        read_in && !waitrequest_out;
    endsequence
    a_wait_first: assert property ($rose(read_in) || $rose(write_in) |-> waitrequest_out)
        else $error("No wait state on new request");
    a_wait_one: assert property (waitrequest_out |=> !waitrequest_out) else $error("Wait state too long");
    a_read_upper: assert property (s_rd_done |-> readdata_out[31:8] == 24'h00_0000)
        else $error("Upper read bits not zero");
    a_unmapped_zero: assert property (s_rd_done ##0 address_in == 7'h7C |-> readdata_out == 32'h0000_0000)
        else $error("Unmapped read not zero");
    a_mask_gate: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq_out)
        else $error("Irq with all masked");
    a_alarm_irq: assert property (alarm_match_in && ctrl_reg[6] && mask_reg[1] |-> ##[1:2] irq_out)
        else $error("Alarm irq missing");
    a_pf_irq: assert property ($rose(powerfail_in) && ctrl_reg[5] && mask_reg[2] |-> ##[1:6] irq_out)
        else $error("Powerfail irq missing");
    a_square_pin: assert property (ctrl_reg[4] && ctrl_reg[3] && $stable(ctrl_reg)
        |-> int_pin_oe_out && int_pin_out == sq_reg[ctrl_reg[1:0]]) else $error("Square wave not on pin");
endmodule // rwd_assertions
bind rwd_top rwd_assertions i_chk (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .alarm_match_in(alarm_match_in), .powerfail_in(powerfail_in),
    .square_in(square_in), .int_pin_out(int_pin_out), .int_pin_oe_out(int_pin_oe_out), .irq_out(irq_out));

// >>> verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, reset_in, read_in, write_in, tick_32hz_in, alarm_match_in, powerfail_in;
    logic        waitrequest_out, int_pin_out, int_pin_oe_out, irq_out;
    logic [6:0]  address_in;
    logic [3:0]  square_in;
    logic [31:0] writedata_in, readdata_out, q;
    int          miscompares = 0;
    int          checks_done = 0;
    rwd_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in), .read_in(read_in),
        .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .tick_32hz_in(tick_32hz_in), .alarm_match_in(alarm_match_in),
        .powerfail_in(powerfail_in), .square_in(square_in), .int_pin_out(int_pin_out),
        .int_pin_oe_out(int_pin_oe_out), .irq_out(irq_out));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One idle edge after release, so the next call never reassigns in the same step
    task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d);
        read_in      <= !wr;
        write_in     <= wr;
        address_in   <= a;
        writedata_in <= {24'h00_0000, d};
        do @(posedge clk_in); while (waitrequest_out !== 1'b0);
        q = readdata_out;
        read_in  <= 1'b0;
        write_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic pulse(input bit alarm);
        if (alarm) alarm_match_in <= 1'b1;
        else tick_32hz_in <= 1'b1;
        @(posedge clk_in);
        alarm_match_in <= 1'b0;
        tick_32hz_in   <= 1'b0;
        @(posedge clk_in);
    endtask
    // ---------------------------------------------------------------
    // Clock, watchdog and tests
    // ---------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        {reset_in, read_in, write_in, tick_32hz_in, alarm_match_in, powerfail_in} = 6'h20;
        address_in   = 7'h00;
        writedata_in = 32'h0000_0000;
        square_in    = 4'h0;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        bus(1, 7'h18, 8'hE8);
        bus(0, 7'h18, 8'h00);
        chk("int_ctrl", q, 32'h0000_00E8);
        bus(1, 7'h7C, 8'hFF);
        bus(0, 7'h7C, 8'h00);
        chk("unmapped", q, 32'h0000_0000);
        bus(1, 7'h1C, 8'h03);
        bus(1, 7'h1C, 8'h45);
        bus(0, 7'h1C, 8'h00);
        chk("wd_lock", q, 32'h0000_0043);
        bus(1, 7'h1C, 8'h83);
        bus(0, 7'h40, 8'h00);
        repeat (2) pulse(0);
        bus(0, 7'h40, 8'h00);
        chk("wd_early", q, 32'h0000_0000);
        bus(1, 7'h1C, 8'h83);
        repeat (2) pulse(0);
        bus(0, 7'h40, 8'h00);
        chk("wd_reload", q, 32'h0000_0000);
        pulse(0);
        bus(0, 7'h40, 8'h00);
        chk("wd_expire", q, 32'h0000_0001);
        bus(1, 7'h44, 8'h07);
        pulse(1);
        @(posedge clk_in);
        chk("irq_alarm", {int_pin_oe_out, int_pin_out, irq_out}, 32'h0000_0007);
        bus(0, 7'h40, 8'h00);
        chk("alarm_flag", q, 32'h0000_0002);
        chk("irq_clear", irq_out, 32'h0000_0000);
        bus(1, 7'h44, 8'h05);
        pulse(1);
        @(posedge clk_in);
        chk("irq_masked", irq_out, 32'h0000_0000);
        bus(0, 7'h40, 8'h00);
        chk("masked_flag", q, 32'h0000_0002);
        powerfail_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("irq_pf", irq_out, 32'h0000_0001);
        bus(0, 7'h40, 8'h00);
        chk("pf_flag", q, 32'h0000_0004);
        powerfail_in <= 1'b0;
        bus(1, 7'h18, 8'hFB);
        square_in <= 4'h8;
        repeat (3) @(posedge clk_in);
        chk("sq_high", {int_pin_oe_out, int_pin_out}, 32'h0000_0003);
        square_in <= 4'h7;
        pulse(1);
        @(posedge clk_in);
        chk("sq_over_irq", {int_pin_oe_out, int_pin_out}, 32'h0000_0002);
        bus(0, 7'h40, 8'h00);
        chk("sq_flag", q, 32'h0000_0002);
        // Open drain, level mode: only the enable moves, the pin value stays low
        bus(1, 7'h18, 8'h40);
        pulse(1);
        @(posedge clk_in);
        chk("od_active", {int_pin_oe_out, int_pin_out}, 32'h0000_0002);
        bus(0, 7'h40, 8'h00);
        chk("od_flag", q, 32'h0000_0002);
        @(posedge clk_in);
        chk("od_release", {int_pin_oe_out, int_pin_out}, 32'h0000_0000);
        // Pulse mode: the pin outlives the flag and drops after the pulse length in ticks
        bus(1, 7'h1C, 8'h00);
        repeat (8) pulse(0);
        bus(1, 7'h18, 8'h8C);
        bus(1, 7'h1C, 8'h02);
        bus(1, 7'h1C, 8'hC0);
        repeat (2) pulse(0);
        @(posedge clk_in);
        chk("wd_pin", {int_pin_oe_out, int_pin_out}, 32'h0000_0003);
        bus(0, 7'h40, 8'h00);
        chk("wd_flag", q, 32'h0000_0001);
        bus(1, 7'h1C, 8'h00);
        chk("pulse_hold", {int_pin_oe_out, int_pin_out}, 32'h0000_0003);
        repeat (7) pulse(0);
        @(posedge clk_in);
        chk("pulse_late", {int_pin_oe_out, int_pin_out}, 32'h0000_0003);
        pulse(0);
        @(posedge clk_in);
        chk("pulse_end", {int_pin_oe_out, int_pin_out}, 32'h0000_0002);
        tally_and_finish;
    end
endmodule // testbench
